// ---- include/bss_cfg.svh ----
// Offsets, field positions, reset values and timing counts of the
// Basic-mode receive sync header status block.
// Assumes inclusion by bare name from the design and verification files.
`ifndef BSS_CFG_SVH
`define BSS_CFG_SVH

// Register offsets
`define BSS_ADDR_CTRL      8'h00
`define BSS_ADDR_STATUS    8'h04
`define BSS_ADDR_INT_STAT  8'h08
`define BSS_ADDR_INT_EN    8'h0c
`define BSS_ADDR_INT_CLR   8'h10
`define BSS_ADDR_ERR_CNT   8'h14

// Control fields
`define BSS_CTRL_MODE67    0
`define BSS_CTRL_SYNC_EN   1
`define BSS_CTRL_FLUSH     2
`define BSS_CTRL_RESET     3'h3

// Status fields
`define BSS_STAT_LOCK      0
`define BSS_STAT_EMPTY     1
`define BSS_STAT_FULL      2
`define BSS_STAT_LEVEL_LSB 8

// Interrupt fields
`define BSS_INT_LOCK_GAIN  0
`define BSS_INT_LOCK_LOST  1
`define BSS_INT_HDR_ERR    2
`define BSS_INT_OVERFLOW   3
`define BSS_INT_UNDERFLOW  4
`define BSS_INT_WIDTH      5
`define BSS_INT_EN_RESET   5'h00

// Sideband bit positions
`define BSS_SB_LOCK        9
`define BSS_SB_HDR_ERR     8
`define BSS_SB_EXTRA       2
`define BSS_SB_CTRL_WORD   1
`define BSS_SB_DATA_WORD   0

// Timing counts, in received blocks
`define BSS_LOCK_GOOD      64
`define BSS_BAD_WINDOW     64
`define BSS_BAD_MAX        16

`endif

// ---- include/bss_pkg.sv ----
// Types shared by the receive sync header status block.
// Assumes bss_cfg.svh is on the include path.
package bss_pkg;

  typedef enum logic [0:0] {
    BSS_HUNT   = 1'b0,
    BSS_LOCKED = 1'b1
  } bss_sync_state_t;

  typedef enum logic [1:0] {
    BSS_M66_RAW  = 2'b00,
    BSS_M66_SYNC = 2'b01,
    BSS_M67_RAW  = 2'b10,
    BSS_M67_SYNC = 2'b11
  } bss_mode_t;

  // A valid header has exactly one of its two bits set
  function automatic logic bss_hdr_ok(input logic [1:0] hdr);
    return (hdr == 2'h1) || (hdr == 2'h2);
  endfunction

endpackage

// ---- rtl/bss_block_sync.sv ----
// Block lock hunter over the two-bit synchronization header.
// Assumes one block per cycle with blk_valid_in high, on the core clock.
`timescale 1ns/1ps
`include "bss_cfg.svh"

module bss_block_sync
  import bss_pkg::*;
#(
  parameter int LOCK_GOOD  = `BSS_LOCK_GOOD,
  parameter int BAD_WINDOW = `BSS_BAD_WINDOW,
  parameter int BAD_MAX    = `BSS_BAD_MAX
) (
  // Clock and control
  input  wire logic       clk_in,
  input  wire logic       reset_in,
  input  wire logic       ce_in,
  input  wire logic       enable_in,
  // Received block header
  input  wire logic       blk_valid_in,
  input  wire logic [1:0] header_in,
  // Status
  output logic            lock_out,
  output logic            hdr_err_out,
  output logic            lock_gain_out,
  output logic            lock_lost_out,
  output logic            slip_out
);

  localparam int CW = $clog2(LOCK_GOOD + BAD_WINDOW + 1) + 1;

  bss_sync_state_t state;
  logic [CW-1:0]   good_cnt;
  logic [CW-1:0]   blk_cnt;
  logic [CW-1:0]   bad_cnt;
  logic            bad;

  assign bad         = enable_in && blk_valid_in && !bss_hdr_ok(header_in);
  assign hdr_err_out = bad;
  assign lock_out    = (state == BSS_LOCKED);

  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      state         <= BSS_HUNT;
      good_cnt      <= '0;
      blk_cnt       <= '0;
      bad_cnt       <= '0;
      lock_gain_out <= 1'b0;
      lock_lost_out <= 1'b0;
      slip_out      <= 1'b0;
    end else if (ce_in) begin
      lock_gain_out <= 1'b0;
      lock_lost_out <= 1'b0;
      slip_out      <= 1'b0;
      if (!enable_in) begin
        state    <= BSS_HUNT;
        good_cnt <= '0;
        blk_cnt  <= '0;
        bad_cnt  <= '0;
      end else if (blk_valid_in) begin
        case (state)
          BSS_HUNT: begin
            if (bad) begin
              good_cnt <= '0;
              slip_out <= 1'b1;
            end else if (good_cnt == CW'(LOCK_GOOD - 1)) begin
              state         <= BSS_LOCKED;
              good_cnt      <= '0;
              blk_cnt       <= '0;
              bad_cnt       <= '0;
              lock_gain_out <= 1'b1;
            end else begin
              good_cnt <= good_cnt + 1'b1;
            end
          end
          BSS_LOCKED: begin
            if (bad && (bad_cnt == CW'(BAD_MAX - 1))) begin
              state         <= BSS_HUNT;
              lock_lost_out <= 1'b1;
              blk_cnt       <= '0;
              bad_cnt       <= '0;
            end else if (blk_cnt == CW'(BAD_WINDOW - 1)) begin
              blk_cnt <= '0;
              bad_cnt <= '0;
            end else begin
              blk_cnt <= blk_cnt + 1'b1;
              bad_cnt <= bad_cnt + CW'(bad);
            end
          end
          default: state <= BSS_HUNT;
        endcase
      end
    end
  end

endmodule // bss_block_sync

// ---- rtl/bss_rx_fifo.sv ----
// Receive FIFO holding one sideband and data word per entry.
// Assumes a single clock; flush empties it in one cycle.
`timescale 1ns/1ps

module bss_rx_fifo #(
  parameter int WIDTH = 74,
  parameter int AW    = 4
) (
  // Clock and control
  input  wire logic             clk_in,
  input  wire logic             reset_in,
  input  wire logic             ce_in,
  input  wire logic             flush_in,
  // Fill side
  input  wire logic             wr_valid_in,
  input  wire logic [WIDTH-1:0] wr_data_in,
  output logic                  wr_ready_out,
  // Drain side
  input  wire logic             rd_ready_in,
  output logic                  rd_valid_out,
  output logic [WIDTH-1:0]      rd_data_out,
  output logic [AW:0]           level_out
);

  logic [WIDTH-1:0] mem [0:(1<<AW)-1];
  logic [AW-1:0]    wptr;
  logic [AW-1:0]    rptr;
  logic [AW:0]      count;
  logic             push;
  logic             pop;

  assign wr_ready_out = (count != (AW+1)'(1 << AW));
  assign rd_valid_out = (count != '0);
  assign rd_data_out  = mem[rptr];
  assign level_out    = count;
  assign push         = wr_valid_in && wr_ready_out;
  assign pop          = rd_ready_in && rd_valid_out;

  always_ff @(posedge clk_in) begin
    if (ce_in && push) begin
      mem[wptr] <= wr_data_in;
    end
  end

  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      wptr  <= '0;
      rptr  <= '0;
      count <= '0;
    end else if (ce_in) begin
      if (flush_in) begin
        wptr  <= '0;
        rptr  <= '0;
        count <= '0;
      end else begin
        if (push) begin
          wptr <= wptr + 1'b1;
        end
        if (pop) begin
          rptr <= rptr + 1'b1;
        end
        count <= count + (AW+1)'(push) - (AW+1)'(pop);
      end
    end
  end

endmodule // bss_rx_fifo

// ---- rtl/bss_rx_top.sv ----
// Basic-mode receive status: block lock, header error and the sync
// header on a ten-bit control sideband, with a read-strobed RX FIFO.
// Assumes received blocks arrive from logic on clk_in (the receive
// core clock), one per cycle with blk_valid_in high.
`timescale 1ns/1ps
`include "bss_cfg.svh"

// Overview of operation
// - In 67-bit mode with block sync, sideband bit 9 is high while block lock holds.
// - In both block sync modes, sideband bit 8 is high for a block with a bad header.
// - In 67-bit mode with block sync, bits 7 to 3 read zero and bit 2 carries header bit 2.
// - In 66-bit mode with block sync, bit 9 is lock, bit 8 header error, bits 7 to 2 zero.
// - In every mode bit 1 set marks a control word and bit 0 set marks a data word.
// - In 67-bit mode without block sync, no lock or error is shown and bits 9 to 3 are zero.
// - Each cycle with the read strobe high delivers one word from the RX FIFO, and none while it is empty or being flushed.
module bss_rx_top
  import bss_pkg::*;
#(
  parameter int DATA_W     = 64,
  parameter int FIFO_AW    = 4,
  parameter int LOCK_GOOD  = `BSS_LOCK_GOOD,
  parameter int BAD_WINDOW = `BSS_BAD_WINDOW,
  parameter int BAD_MAX    = `BSS_BAD_MAX
) (
  // Clock, reset and enable
  input  wire logic              clk_in,
  input  wire logic              reset_in,
  input  wire logic              ce_in,
  // Received blocks
  input  wire logic              blk_valid_in,
  input  wire logic [2:0]        blk_header_in,
  input  wire logic [DATA_W-1:0] blk_data_in,
  output logic                   blk_slip_out,
  // User fabric read side
  input  wire logic              rx_fifo_read_strobe_in,
  output logic [DATA_W-1:0]      rx_data_out,
  output logic [9:0]             rx_control_sideband_out,
  output logic                   rx_data_valid_out,
  // Register port
  input  wire logic [7:0]        reg_addr_in,
  input  wire logic [31:0]       reg_wdata_in,
  input  wire logic              reg_wr_in,
  input  wire logic              reg_rd_in,
  output logic [31:0]            reg_rdata_out,
  // Interrupt
  output logic                   irq_out
);

  localparam int FW = DATA_W + 10;

  // Register state
  logic [2:0]                ctrl;
  logic [`BSS_INT_WIDTH-1:0] int_stat;
  logic [`BSS_INT_WIDTH-1:0] int_en;
  logic [15:0]               err_cnt;

  // Internal signals
  bss_mode_t                 mode;
  logic                      sync_lock;
  logic                      sync_hdr_err;
  logic                      lock_gain;
  logic                      lock_lost;
  logic                      sync_slip;
  logic [9:0]                sideband;
  logic                      fifo_ready;
  logic                      fifo_valid;
  logic [FW-1:0]             fifo_rd_data;
  logic [FIFO_AW:0]          fifo_level;
  logic                      fifo_pop;
  logic                      overflow;
  logic                      underflow;
  logic                      flush;
  logic                      err_event;
  logic [`BSS_INT_WIDTH-1:0] events;
  logic [`BSS_INT_WIDTH-1:0] clr_mask;
  logic [31:0]               next_rdata;

  assign mode = bss_mode_t'({ctrl[`BSS_CTRL_MODE67], ctrl[`BSS_CTRL_SYNC_EN]});

  // Sideband layout per Basic mode
  function automatic logic [9:0] build_sideband(
    input bss_mode_t  m,
    input logic       lock,
    input logic       herr,
    input logic [2:0] hdr
  );
    logic [9:0] sb;
    sb = '0;
    sb[`BSS_SB_CTRL_WORD] = hdr[1];
    sb[`BSS_SB_DATA_WORD] = hdr[0];
    case (m)
      BSS_M67_SYNC: begin
        sb[`BSS_SB_LOCK]    = lock;
        sb[`BSS_SB_HDR_ERR] = herr;
        sb[`BSS_SB_EXTRA]   = hdr[2];
      end
      BSS_M66_SYNC: begin
        sb[`BSS_SB_LOCK]    = lock;
        sb[`BSS_SB_HDR_ERR] = herr;
      end
      BSS_M67_RAW: begin
        sb[`BSS_SB_EXTRA]   = hdr[2];
      end
      BSS_M66_RAW: begin
        sb = sb & 10'h003;
      end
      default: sb = '0;
    endcase
    return sb;
  endfunction

  // Lock hunting runs only in the block sync modes
  bss_block_sync #(
    .LOCK_GOOD  (LOCK_GOOD),
    .BAD_WINDOW (BAD_WINDOW),
    .BAD_MAX    (BAD_MAX)
  ) u_sync (
    .clk_in        (clk_in),
    .reset_in      (reset_in),
    .ce_in         (ce_in),
    .enable_in     (ctrl[`BSS_CTRL_SYNC_EN]),
    .blk_valid_in  (blk_valid_in),
    .header_in     (blk_header_in[1:0]),
    .lock_out      (sync_lock),
    .hdr_err_out   (sync_hdr_err),
    .lock_gain_out (lock_gain),
    .lock_lost_out (lock_lost),
    .slip_out      (sync_slip)
  );

  assign sideband = build_sideband(mode, sync_lock, sync_hdr_err, blk_header_in);

  // FIFO write side; the flush bit in the control register empties it
  assign flush = reg_wr_in && (reg_addr_in == `BSS_ADDR_CTRL)
                 && reg_wdata_in[`BSS_CTRL_FLUSH];

  bss_rx_fifo #(
    .WIDTH (FW),
    .AW    (FIFO_AW)
  ) u_fifo (
    .clk_in       (clk_in),
    .reset_in     (reset_in),
    .ce_in        (ce_in),
    .flush_in     (flush),
    .wr_valid_in  (blk_valid_in),
    .wr_data_in   ({sideband, blk_data_in}),
    .wr_ready_out (fifo_ready),
    .rd_ready_in  (rx_fifo_read_strobe_in),
    .rd_valid_out (fifo_valid),
    .rd_data_out  (fifo_rd_data),
    .level_out    (fifo_level)
  );

  // One word leaves the FIFO for each strobed cycle that finds it non-empty and not being flushed
  assign fifo_pop  = rx_fifo_read_strobe_in && fifo_valid && !flush;
  assign overflow  = blk_valid_in && !fifo_ready;
  assign underflow = rx_fifo_read_strobe_in && !fifo_valid;
  assign err_event = sync_hdr_err && blk_valid_in;

  // Read data register: word appears in the cycle after the strobe
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      rx_data_out             <= '0;
      rx_control_sideband_out <= '0;
      rx_data_valid_out       <= 1'b0;
    end else if (ce_in) begin
      rx_data_valid_out <= fifo_pop;
      if (fifo_pop) begin
        rx_data_out             <= fifo_rd_data[DATA_W-1:0];
        rx_control_sideband_out <= fifo_rd_data[FW-1:DATA_W];
      end
    end
  end

  // Slip request to the gearbox
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      blk_slip_out <= 1'b0;
    end else if (ce_in) begin
      blk_slip_out <= sync_slip;
    end
  end

  // Control register
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      ctrl <= `BSS_CTRL_RESET;
    end else if (ce_in) begin
      if (reg_wr_in && (reg_addr_in == `BSS_ADDR_CTRL)) begin
        ctrl <= {1'b0, reg_wdata_in[`BSS_CTRL_SYNC_EN], reg_wdata_in[`BSS_CTRL_MODE67]};
      end
    end
  end

  // Interrupt enable register
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      int_en <= `BSS_INT_EN_RESET;
    end else if (ce_in) begin
      if (reg_wr_in && (reg_addr_in == `BSS_ADDR_INT_EN)) begin
        int_en <= reg_wdata_in[`BSS_INT_WIDTH-1:0];
      end
    end
  end

  // Sticky status; a new event wins over a clear in the same cycle
  always_comb begin
    events = '0;
    events[`BSS_INT_LOCK_GAIN] = lock_gain;
    events[`BSS_INT_LOCK_LOST] = lock_lost;
    events[`BSS_INT_HDR_ERR]   = err_event;
    events[`BSS_INT_OVERFLOW]  = overflow;
    events[`BSS_INT_UNDERFLOW] = underflow;
    clr_mask = '0;
    if (reg_wr_in && (reg_addr_in == `BSS_ADDR_INT_CLR)) begin
      clr_mask = reg_wdata_in[`BSS_INT_WIDTH-1:0];
    end
  end

  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      int_stat <= '0;
    end else if (ce_in) begin
      int_stat <= (int_stat & ~clr_mask) | events;
    end
  end

  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      irq_out <= 1'b0;
    end else if (ce_in) begin
      irq_out <= |(int_stat & int_en);
    end
  end

  // Saturating header error count, cleared by reading it
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      err_cnt <= '0;
    end else if (ce_in) begin
      if (reg_rd_in && (reg_addr_in == `BSS_ADDR_ERR_CNT)) begin
        err_cnt <= {15'h0000, err_event};
      end else if (err_event && (err_cnt != 16'hffff)) begin
        err_cnt <= err_cnt + 16'h0001;
      end
    end
  end

  // Read mux; unmapped and write-only offsets read zero
  always_comb begin
    next_rdata = '0;
    case (reg_addr_in)
      `BSS_ADDR_CTRL: begin
        next_rdata[1:0] = ctrl[1:0];
      end
      `BSS_ADDR_STATUS: begin
        next_rdata[`BSS_STAT_LOCK]  = sync_lock;
        next_rdata[`BSS_STAT_EMPTY] = !fifo_valid;
        next_rdata[`BSS_STAT_FULL]  = !fifo_ready;
        next_rdata[`BSS_STAT_LEVEL_LSB +: FIFO_AW+1] = fifo_level;
      end
      `BSS_ADDR_INT_STAT: begin
        next_rdata[`BSS_INT_WIDTH-1:0] = int_stat;
      end
      `BSS_ADDR_INT_EN: begin
        next_rdata[`BSS_INT_WIDTH-1:0] = int_en;
      end
      `BSS_ADDR_ERR_CNT: begin
        next_rdata[15:0] = err_cnt;
      end
      default: next_rdata = '0;
    endcase
  end

  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      reg_rdata_out <= '0;
    end else if (ce_in) begin
      reg_rdata_out <= reg_rd_in ? next_rdata : 32'h00000000;
    end
  end

endmodule // bss_rx_top

// ---- verif/bss_rx_checker_assertions.sv ----
// Port-level checks of the Basic-mode receive sideband and RX FIFO read.
// Assumes it is bound to bss_rx_top; one clock, synchronous reset.
`timescale 1ns/1ps
`include "bss_cfg.svh"

module bss_rx_checker #(
  parameter int DATA_W = 64
) (
  // Clock, reset and block input
  input wire logic              clk_in,
  input wire logic              reset_in,
  input wire logic              ce_in,
  input wire logic              blk_valid_in,
  input wire logic [2:0]        blk_header_in,
  input wire logic              blk_slip_out,
  // Read side
  input wire logic              rx_fifo_read_strobe_in,
  input wire logic [DATA_W-1:0] rx_data_out,
  input wire logic [9:0]        rx_control_sideband_out,
  input wire logic              rx_data_valid_out,
  // Register port
  input wire logic [7:0]        reg_addr_in,
  input wire logic [31:0]       reg_wdata_in,
  input wire logic              reg_wr_in,
  input wire logic              reg_rd_in,
  input wire logic [31:0]       reg_rdata_out
);
  logic [1:0] mode_q;
  logic       clean_q;
  logic       ctrl_wr;
  logic       blk_bad;
  logic       sb_bad;

  assign ctrl_wr = ce_in && reg_wr_in && (reg_addr_in == `BSS_ADDR_CTRL);
  assign blk_bad = blk_valid_in && (blk_header_in[1:0] inside {2'h0, 2'h3});
  assign sb_bad  = rx_control_sideband_out[1:0] inside {2'h0, 2'h3};

  // Mode of the words read is only known after a flush emptied the FIFO
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      mode_q  <= 2'h3;
      clean_q <= 1'b1;
    end else if (ctrl_wr) begin
      mode_q  <= reg_wdata_in[1:0];
      clean_q <= reg_wdata_in[`BSS_CTRL_FLUSH] && !blk_valid_in;
    end
  end

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (reset_in);

  a_valid_after_strobe: assert property (
    rx_data_valid_out && $past(ce_in) |-> $past(rx_fifo_read_strobe_in))
    else $error("valid without a strobe");
  a_sideband_holds: assert property (
    !rx_data_valid_out |-> $stable(rx_control_sideband_out))
    else $error("sideband changed without a word");
  a_unused_bits_zero: assert property (
    rx_control_sideband_out[7:3] == 5'h00)
    else $error("unused sideband bits set");
  a_herr_bad_hdr: assert property (
    rx_control_sideband_out[`BSS_SB_HDR_ERR] |-> sb_bad)
    else $error("header error on a good header");
  a_herr_in_sync: assert property (
    clean_q && mode_q[1] && rx_data_valid_out |-> rx_control_sideband_out[8] == sb_bad)
    else $error("header error flag wrong");
  a_raw_no_status: assert property (
    clean_q && !mode_q[1] && rx_data_valid_out |-> rx_control_sideband_out[9:8] == 2'h0)
    else $error("status shown without block sync");
  a_bit2_66_zero: assert property (
    clean_q && !mode_q[0] && rx_data_valid_out |-> !rx_control_sideband_out[2])
    else $error("bit 2 set in 66-bit mode");
  a_rdata_after_read: assert property (
    reg_rdata_out != 32'h0 |-> $past(reg_rd_in))
    else $error("read data outside its cycle");
  a_slip_after_bad: assert property (
    blk_slip_out |-> $past(blk_bad, 2))
    else $error("slip without a bad header");
endmodule // bss_rx_checker

bind bss_rx_top bss_rx_checker #(.DATA_W(DATA_W)) u_checker (
  .clk_in(clk_in), .reset_in(reset_in), .ce_in(ce_in), .blk_valid_in(blk_valid_in),
  .blk_header_in(blk_header_in), .blk_slip_out(blk_slip_out),
  .rx_fifo_read_strobe_in(rx_fifo_read_strobe_in), .rx_data_out(rx_data_out),
  .rx_control_sideband_out(rx_control_sideband_out), .rx_data_valid_out(rx_data_valid_out),
  .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in),
  .reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out));

// ---- verif/bss_fabric_reader.sv ----
// User fabric model that pulls words from the RX FIFO by read strobe.
// Assumes the block samples the strobe on the rising edge of clk_in.
`timescale 1ns/1ps

module bss_fabric_reader #(
  parameter int DATA_W = 64
) (
  // Clock and reset
  input  wire logic              clk_in,
  input  wire logic              reset_in,
  // Bench control
  input  wire logic              go_in,
  input  wire logic              slow_in,
  input  wire logic [7:0]        target_in,
  // Read side
  output logic                   strobe_out,
  input  wire logic [DATA_W-1:0] data_in,
  input  wire logic [9:0]        sideband_in,
  input  wire logic              valid_in
);
  logic [7:0]        issued;
  logic [DATA_W-1:0] got_data[$];
  logic [9:0]        got_sb[$];

  // One strobe cycle per word; slow mode leaves a gap after each
  always_ff @(posedge clk_in) begin
    if (reset_in || !go_in) begin
      strobe_out <= 1'b0;
      issued     <= 8'h00;
    end else begin
      strobe_out <= (issued + 8'(strobe_out) < target_in) && !(slow_in && strobe_out);
      issued     <= issued + 8'(strobe_out);
    end
  end

  always @(posedge clk_in) begin
    if (valid_in) begin
      got_data.push_back(data_in);
      got_sb.push_back(sideband_in);
    end
  end
endmodule // bss_fabric_reader

// ---- verif/basic_rx_sync_header_status_tb_top.sv ----
// Self-checking bench for the Basic-mode receive sync header status top.
// Assumes bss_pkg, the checker and the fabric reader are compiled first.
`timescale 1ns/1ps
`include "bss_cfg.svh"

module basic_rx_sync_header_status_tb_top
  import bss_pkg::*;
;
  logic        clk_in = 1'b0;
  logic        reset_in = 1'b1;
  logic        blk_valid_in = 1'b0;
  logic [2:0]  blk_header_in = 3'h0;
  logic [63:0] blk_data_in = 64'h0;
  logic        go = 1'b0;
  logic        slow = 1'b0;
  logic [7:0]  target = 8'h00;
  logic [7:0]  reg_addr_in = 8'h00;
  logic [31:0] reg_wdata_in = 32'h0;
  logic        reg_wr_in = 1'b0;
  logic        reg_rd_in = 1'b0;
  logic        ce = 1'b1;
  logic        slip;
  logic        strobe;
  logic        dvalid;
  logic        irq;
  logic [63:0] rword;
  logic [9:0]  sb;
  logic [31:0] reg_rdata_out;
  int          errors = 0;
  int          samples_checked = 0;
  int          slips = 0;

  always #10 clk_in = ~clk_in;

  // Counts slip pulses seen at the block's output
  always @(posedge clk_in) begin
    if (slip === 1'b1) slips++;
  end

  bss_rx_top #(.FIFO_AW(4), .LOCK_GOOD(4), .BAD_WINDOW(8), .BAD_MAX(3)) dut (
    .clk_in(clk_in), .reset_in(reset_in), .ce_in(ce), .blk_valid_in(blk_valid_in),
    .blk_header_in(blk_header_in), .blk_data_in(blk_data_in), .blk_slip_out(slip),
    .rx_fifo_read_strobe_in(strobe), .rx_data_out(rword), .rx_control_sideband_out(sb),
    .rx_data_valid_out(dvalid), .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in),
    .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out),
    .irq_out(irq));

  bss_fabric_reader u_rd (
    .clk_in(clk_in), .reset_in(reset_in), .go_in(go), .slow_in(slow), .target_in(target),
    .strobe_out(strobe), .data_in(rword), .sideband_in(sb), .valid_in(dvalid));

  task automatic summarize();
    $display("errors=%0d samples_checked=%0d", errors, samples_checked);
    if (errors == 0 && samples_checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  task automatic expect_eq(input logic [63:0] got, input logic [63:0] exp, input string what);
    samples_checked++;
    if (got !== exp) begin
      errors++;
      $display("mismatch at %0t: %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_in);
    reg_addr_in  <= a;
    reg_wdata_in <= d;
    reg_wr_in    <= 1'b1;
    @(posedge clk_in);
    reg_wr_in    <= 1'b0;
  endtask

  task automatic reg_read(input logic [7:0] a, input logic [31:0] exp, input logic [31:0] m,
                          input string what);
    @(posedge clk_in);
    reg_addr_in <= a;
    reg_rd_in   <= 1'b1;
    @(posedge clk_in);
    reg_rd_in   <= 1'b0;
    #1;
    expect_eq(64'(reg_rdata_out & m), 64'(exp), what);
  endtask

  task automatic send_blk(input logic [2:0] h, input logic [63:0] d);
    @(posedge clk_in);
    blk_valid_in  <= 1'b1;
    blk_header_in <= h;
    blk_data_in   <= d;
  endtask

  task automatic idle_blk();
    @(posedge clk_in);
    blk_valid_in <= 1'b0;
  endtask

  // Asks the reader for n strobes and waits for want words
  task automatic drain(input int n, input int want, input logic s);
    int k;
    u_rd.got_data.delete();
    u_rd.got_sb.delete();
    @(posedge clk_in);
    target <= 8'(n);
    slow   <= s;
    go     <= 1'b1;
    for (k = 0; k < 100 && u_rd.got_sb.size() < want; k++) @(posedge clk_in);
    repeat (4) @(posedge clk_in);
    go <= 1'b0;
    #1;
    if (k == 100) begin
      errors++;
      $display("mismatch at %0t: drain timed out", $time);
      summarize();
    end
  endtask

  task automatic t_reset_regs();
    reg_read(`BSS_ADDR_CTRL, 32'h3, '1, "ctrl reset");
    reg_read(`BSS_ADDR_STATUS, 32'h2, '1, "status reset");
    reg_read(8'h40, 32'h0, '1, "unmapped");
  endtask

  task automatic t_mode(input bss_mode_t m, input logic s);
    logic [2:0] hs[8] = '{3'h0, 3'h1, 3'h2, 3'h5, 3'h6, 3'h1, 3'h7, 3'h2};
    logic [7:0] lk = 8'he0;
    logic       bad;
    int         i;
    reg_write(`BSS_ADDR_CTRL, {29'h0, 1'b1, m[0], m[1]});
    slips = 0;
    for (i = 0; i < 8; i++) send_blk(hs[i], {56'h0123_4567_89ab_cd, 8'(i)});
    idle_blk();
    drain(8, 8, s);
    expect_eq(slips, m[0], "slip count");
    expect_eq(u_rd.got_sb.size(), 8, "word count");
    for (i = 0; i < u_rd.got_sb.size(); i++) begin
      bad = hs[i][1:0] inside {2'h0, 2'h3};
      expect_eq(u_rd.got_data[i], {56'h0123_4567_89ab_cd, 8'(i)}, "data");
      expect_eq(u_rd.got_sb[i], {m[0] & lk[i], m[0] & bad, 5'h0, m[1] & hs[i][2],
                hs[i][1:0]}, "sideband");
    end
    reg_read(`BSS_ADDR_ERR_CNT, {30'h0, m[0], 1'b0}, '1, "error count");
    reg_read(`BSS_ADDR_STATUS, {30'h0, 1'b1, m[0]}, 32'h3, "lock and empty");
  endtask

  task automatic t_fifo_irq();
    int i;
    reg_write(`BSS_ADDR_CTRL, 32'h4);
    reg_write(`BSS_ADDR_INT_CLR, 32'h1f);
    reg_write(`BSS_ADDR_INT_EN, 32'h10);
    drain(1, 0, 1'b0);
    expect_eq(u_rd.got_sb.size(), 0, "word from empty fifo");
    expect_eq(irq, 1'b1, "underflow irq");
    reg_write(`BSS_ADDR_INT_EN, 32'h0);
    #41;
    expect_eq(irq, 1'b0, "masked irq");
    reg_write(`BSS_ADDR_INT_EN, 32'h18);
    reg_write(`BSS_ADDR_INT_CLR, 32'h10);
    #41;
    expect_eq(irq, 1'b0, "cleared irq");
    for (i = 0; i < 17; i++) send_blk(3'h2, 64'(i));
    idle_blk();
    reg_read(`BSS_ADDR_STATUS, 32'h1004, '1, "fifo full");
    reg_read(`BSS_ADDR_INT_STAT, 32'h08, 32'h18, "overflow");
    expect_eq(irq, 1'b1, "overflow irq");
    drain(17, 16, 1'b1);
    expect_eq(u_rd.got_sb.size(), 16, "words from full fifo");
    expect_eq(u_rd.got_data[15], 64'hf, "last kept word");
    reg_read(`BSS_ADDR_INT_STAT, 32'h18, 32'h18, "underflow");
  endtask

  task automatic t_lock_loss();
    int i;
    reg_write(`BSS_ADDR_CTRL, 32'h7);
    reg_write(`BSS_ADDR_INT_CLR, 32'h1f);
    for (i = 0; i < 8; i++) send_blk((i inside {[4:6]}) ? 3'h3 : 3'h1, 64'(i));
    idle_blk();
    drain(8, 8, 1'b0);
    expect_eq({u_rd.got_sb[6][9], u_rd.got_sb[7][9]}, 2'b10, "lock bit");
    reg_read(`BSS_ADDR_INT_STAT, 32'h3, 32'h3, "lock gained and lost");
    reg_read(`BSS_ADDR_STATUS, 32'h0, 32'h1, "lock dropped");
  endtask

  // A block offered while the clock enable is low must not enter the FIFO
  task automatic t_freeze();
    @(posedge clk_in);
    ce <= 1'b0;
    send_blk(3'h1, 64'h5a);
    idle_blk();
    @(posedge clk_in);
    ce <= 1'b1;
    reg_read(`BSS_ADDR_STATUS, 32'h2, 32'h2, "frozen fifo stays empty");
  endtask

  initial begin
    repeat (10) @(posedge clk_in);
    reset_in <= 1'b0;
    t_reset_regs();
    t_mode(BSS_M67_SYNC, 1'b0);
    t_mode(BSS_M66_RAW, 1'b1);
    t_mode(BSS_M66_SYNC, 1'b1);
    t_mode(BSS_M67_RAW, 1'b0);
    t_fifo_irq();
    t_lock_loss();
    t_freeze();
    summarize();
  end

  initial begin
    repeat (20000) @(posedge clk_in);
    errors++;
    $display("mismatch at %0t: run timed out", $time);
    summarize();
  end
endmodule // basic_rx_sync_header_status_tb_top
